// ===== rtl/okm_pkg.sv
// okm_pkg: register map, field layout, reset values and codes shared by
// the on-off-keying receive modem configuration bank.
// assumes byte-wide registers reached as one aligned 32-bit word each.
package okm_pkg;

   // register indices as printed; byte address is four times the index
   localparam logic [6:0] IDX_IF_FILTER_BANDWIDTH = 7'h1c;
   localparam logic [6:0] IDX_CR_OVERSAMPLE_RATIO = 7'h20;
   localparam logic [6:0] IDX_CR_OFFSET_2 = 7'h21;
   localparam logic [6:0] IDX_CR_OFFSET_1 = 7'h22;
   localparam logic [6:0] IDX_CR_OFFSET_0 = 7'h23;
   localparam logic [6:0] IDX_CR_LOOP_GAIN_1 = 7'h24;
   localparam logic [6:0] IDX_CR_LOOP_GAIN_0 = 7'h25;
   localparam logic [6:0] IDX_TX_RATE_HIGH = 7'h6e;
   localparam logic [6:0] IDX_TX_RATE_LOW = 7'h6f;
   localparam logic [6:0] IDX_MODULATION_CONTROL_1 = 7'h70;
   localparam logic [6:0] IDX_MODULATION_CONTROL_2 = 7'h71;
   // status word of our own: decoded modem state
   localparam logic [6:0] IDX_MODEM_STATUS = 7'h7f;

   // if_filter_bandwidth fields
   localparam int FB_SKIP_BIT = 7;
   localparam int FB_DEC_LSB = 4;
   localparam int FB_SET_LSB = 0;
   // cr_offset_2 fields: oversample ratio upper bits and offset upper bits
   localparam int CO2_OSR_LSB = 5;
   localparam int CO2_OFF_LSB = 0;
   // modulation control 1 fields
   localparam int MC1_SCALE_BIT = 5;
   localparam int MC1_MANCH_BIT = 1;
   // modulation control 2 fields
   localparam int MC2_TYPE_LSB = 0;

   typedef enum logic [1:0] {
      OKM_MOD_UNMOD,
      OKM_MOD_ON_OFF_KEYING,
      OKM_MOD_FSK,
      OKM_MOD_GFSK
   } okm_mod_t;

   // reset values (plain defaults)
   localparam logic [7:0] RST_IF_FILTER_BANDWIDTH = 8'h01;
   localparam logic [7:0] RST_CR_OVERSAMPLE_RATIO = 8'h64;
   localparam logic [7:0] RST_CR_OFFSET_2 = 8'h01;
   localparam logic [7:0] RST_CR_OFFSET_1 = 8'h47;
   localparam logic [7:0] RST_CR_OFFSET_0 = 8'hae;
   localparam logic [7:0] RST_CR_LOOP_GAIN_1 = 8'h02;
   localparam logic [7:0] RST_CR_LOOP_GAIN_0 = 8'h8f;
   localparam logic [7:0] RST_TX_RATE_HIGH = 8'h0a;
   localparam logic [7:0] RST_TX_RATE_LOW = 8'h3d;
   localparam logic [7:0] RST_MODULATION_CONTROL_1 = 8'h0c;
   localparam logic [7:0] RST_MODULATION_CONTROL_2 = 8'h00;

   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage : okm_pkg

// ===== rtl/okm_reg_byte.sv
// okm_reg_byte: one byte register with per-bit write mask.
// assumes writes come from the bus slave on the same clock.
`timescale 1ns/10ps
module okm_reg_byte #(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // write side
   input wire logic i_we,
   input wire logic [7:0] i_mask,
   input wire logic [7:0] i_wdata,
   // stored value
   output logic [7:0] o_q
);

   logic [7:0] q_r;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q_r <= RESET_VALUE; // RULE12
      end else if (i_we) begin
         // bits with a clear mask bit keep their value
         q_r <= (q_r & ~i_mask) | (i_wdata & i_mask); // RULE11
      end
   end

   assign o_q = q_r;

endmodule : okm_reg_byte

// ===== rtl/okm_rate_decode.sv
// okm_rate_decode: decodes the stored configuration into the values the
// demodulator uses: effective chip rate, filter selection, modem fields.
// assumes inputs come from registers on the same clock.
`timescale 1ns/10ps
module okm_rate_decode (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // configuration
   input wire logic [7:0] i_mc1,
   input wire logic [7:0] i_mc2,
   input wire logic [15:0] i_rate,
   input wire logic [7:0] i_filt,
   // decoded
   output logic o_ook_en,
   output logic o_manch_term,
   output logic o_rate_scale,
   output logic [16:0] o_eff_rate,
   output logic o_skip,
   output logic [2:0] o_dec_exp,
   output logic [3:0] o_filset,
   output logic o_filt_valid
);

   // filter code legal for the chosen divide-by-three path
   function automatic logic filt_ok(input logic skip, input logic [3:0] f);
      if (!skip) begin
         filt_ok = (f >= 4'h1) && (f <= 4'h7); // RULE5
      end else begin
         filt_ok = (f != 4'h0) && (f != 4'h5) && (f != 4'h6)
            && (f != 4'h7); // RULE5
      end
   endfunction : filt_ok

   logic manch;

   assign manch = i_mc1[okm_pkg::MC1_MANCH_BIT];

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_ook_en <= 1'b0;
         o_manch_term <= 1'b0;
         o_rate_scale <= 1'b0;
         o_eff_rate <= 17'h00000;
         o_skip <= 1'b0;
         o_dec_exp <= 3'h0;
         o_filset <= 4'h0;
         o_filt_valid <= 1'b0;
      end else begin
         o_ook_en <= (okm_pkg::okm_mod_t'(i_mc2[okm_pkg::MC2_TYPE_LSB +: 2])
            == okm_pkg::OKM_MOD_ON_OFF_KEYING); // RULE1
         o_manch_term <= manch; // RULE10
         o_rate_scale <= i_mc1[okm_pkg::MC1_SCALE_BIT]; // RULE3
         // manchester doubles the chip rate
         o_eff_rate <= manch ? {i_rate, 1'b0} : {1'b0, i_rate}; // RULE4
         o_skip <= i_filt[okm_pkg::FB_SKIP_BIT];
         o_dec_exp <= i_filt[okm_pkg::FB_DEC_LSB +: 3]; // RULE6
         o_filset <= i_filt[okm_pkg::FB_SET_LSB +: 4];
         o_filt_valid <= filt_ok(i_filt[okm_pkg::FB_SKIP_BIT],
            i_filt[okm_pkg::FB_SET_LSB +: 4]); // RULE5
      end
   end

endmodule : okm_rate_decode

// ===== rtl/okm_config.sv
// okm_config: configuration register bank of the on-off-keying receive
// modem, reached over an Avalon-MM slave with waitrequest.
// assumes one clock; the host computes oversampling, offset and gain.
// Operation
// RULE1 - modulation type code for on-off keying selects that mode
// RULE2 - 16-bit rate from high byte and next-address low byte
// RULE3 - software sets scale bit for rates up to 30 kbps
// RULE4 - manchester enable doubles the effective chip rate
// RULE5 - filter chosen from bypass bit and filter-set code
// RULE6 - software picks decimation exponent from effective rate
// RULE7 - 11-bit oversampling ratio held across two registers
// RULE8 - 20-bit clock recovery offset held across three registers
// RULE9 - 11-bit timing loop gain held across two registers
// RULE10 - manchester term is one when enabled, zero when disabled
// RULE11 - shared byte at 0x21 splits ratio and offset bits cleanly
// RULE12 - registers read back last write and reset to defaults
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module okm_config (
   // clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RST,
   // avalon-mm slave
   input wire logic [8:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   output logic [31:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST,
   // configuration to the demodulator
   output logic O_OOK_EN,
   output logic O_MANCH_TERM,
   output logic O_RATE_SCALE,
   output logic [15:0] O_DATA_RATE,
   output logic [16:0] O_EFF_RATE,
   output logic O_DIVIDE_BY_THREE_SKIP,
   output logic [2:0] O_DEC_EXP,
   output logic [3:0] O_FILSET,
   output logic O_FILT_VALID,
   output logic [10:0] O_OSR,
   output logic [19:0] O_NCO_OFFSET,
   output logic [10:0] O_LOOP_GAIN
);

   localparam int NREG = 11;

   // register index table, position in the bank
   localparam logic [6:0] REG_IDX [NREG] = '{
      okm_pkg::IDX_IF_FILTER_BANDWIDTH,
      okm_pkg::IDX_CR_OVERSAMPLE_RATIO,
      okm_pkg::IDX_CR_OFFSET_2,
      okm_pkg::IDX_CR_OFFSET_1,
      okm_pkg::IDX_CR_OFFSET_0,
      okm_pkg::IDX_CR_LOOP_GAIN_1,
      okm_pkg::IDX_CR_LOOP_GAIN_0,
      okm_pkg::IDX_TX_RATE_HIGH,
      okm_pkg::IDX_TX_RATE_LOW,
      okm_pkg::IDX_MODULATION_CONTROL_1,
      okm_pkg::IDX_MODULATION_CONTROL_2
   };
   localparam logic [7:0] REG_RST [NREG] = '{
      okm_pkg::RST_IF_FILTER_BANDWIDTH,
      okm_pkg::RST_CR_OVERSAMPLE_RATIO,
      okm_pkg::RST_CR_OFFSET_2,
      okm_pkg::RST_CR_OFFSET_1,
      okm_pkg::RST_CR_OFFSET_0,
      okm_pkg::RST_CR_LOOP_GAIN_1,
      okm_pkg::RST_CR_LOOP_GAIN_0,
      okm_pkg::RST_TX_RATE_HIGH,
      okm_pkg::RST_TX_RATE_LOW,
      okm_pkg::RST_MODULATION_CONTROL_1,
      okm_pkg::RST_MODULATION_CONTROL_2
   };

   typedef enum logic [1:0] {
      OKM_IDLE,
      OKM_ACK
   } okm_state_t;

   okm_state_t state_r;
   okm_state_t state_nxt;
   logic [7:0] q [NREG];
   logic [NREG-1:0] hit;
   logic [NREG-1:0] we;
   logic [7:0] wmask;
   logic addr_ok;
   logic [6:0] idx;
   logic [31:0] rdata_nxt;
   logic [31:0] rdata_r;
   logic [7:0] status;

   // byte address to register index; low two bits must be zero
   function automatic logic [6:0] word_index(input logic [8:0] a);
      word_index = a[8:2];
   endfunction : word_index

   assign idx = word_index(I_AVS_ADDRESS);
   assign addr_ok = (I_AVS_ADDRESS[1:0] == 2'b00);
   // only lane 0 holds data; other lanes read as zero
   assign wmask = {8{I_AVS_BYTEENABLE[0]}};

   // one answer cycle: request taken in idle, waitrequest drops in ack
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         OKM_IDLE: begin
            if (I_AVS_READ || I_AVS_WRITE) begin
               state_nxt = OKM_ACK;
            end
         end
         OKM_ACK: begin
            state_nxt = OKM_IDLE;
         end
         default: begin
            state_nxt = OKM_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         state_r <= OKM_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign O_AVS_WAITREQUEST = (state_r != OKM_ACK);

   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_reg
         assign hit[g] = addr_ok && (idx == REG_IDX[g]);
         // write takes effect at the edge where waitrequest is low
         assign we[g] = hit[g] && I_AVS_WRITE && (state_r == OKM_ACK);
         okm_reg_byte #(
            .RESET_VALUE(REG_RST[g])
         ) u_reg (
            .i_clk(I_SYS_CLK),
            .i_rst(I_RST),
            .i_we(we[g]),
            .i_mask(wmask),
            .i_wdata(I_AVS_WRITEDATA[7:0]),
            .o_q(q[g])
         ); // RULE12
      end
   endgenerate

   assign status = {5'h00, O_FILT_VALID, O_MANCH_TERM, O_OOK_EN};

   // read mux, registered so data stand with waitrequest low
   always_comb begin
      rdata_nxt = okm_pkg::UNMAPPED_READ;
      if (addr_ok && idx == okm_pkg::IDX_MODEM_STATUS) begin
         rdata_nxt = {24'h000000, status};
      end else begin
         for (int i = 0; i < NREG; i++) begin
            if (hit[i]) begin
               rdata_nxt = {24'h000000, q[i]}; // RULE12
            end
         end
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         rdata_r <= 32'h0000_0000;
      end else if (state_r == OKM_IDLE) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign O_AVS_READDATA = rdata_r;

   okm_rate_decode u_decode (
      .i_clk(I_SYS_CLK),
      .i_rst(I_RST),
      .i_mc1(q[9]),
      .i_mc2(q[10]),
      .i_rate({q[7], q[8]}),
      .i_filt(q[0]),
      .o_ook_en(O_OOK_EN),
      .o_manch_term(O_MANCH_TERM),
      .o_rate_scale(O_RATE_SCALE),
      .o_eff_rate(O_EFF_RATE),
      .o_skip(O_DIVIDE_BY_THREE_SKIP),
      .o_dec_exp(O_DEC_EXP),
      .o_filset(O_FILSET),
      .o_filt_valid(O_FILT_VALID)
   ); // RULE1

   // field outputs registered from the stored bytes
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         O_DATA_RATE <= 16'h0000;
         O_OSR <= 11'h000;
         O_NCO_OFFSET <= 20'h00000;
         O_LOOP_GAIN <= 11'h000;
      end else begin
         O_DATA_RATE <= {q[7], q[8]}; // RULE2
         O_OSR <= {q[2][okm_pkg::CO2_OSR_LSB +: 3], q[1]}; // RULE7
         O_NCO_OFFSET <= {q[2][okm_pkg::CO2_OFF_LSB +: 4], q[3],
            q[4]}; // RULE8
         O_LOOP_GAIN <= {q[5][2:0], q[6]}; // RULE9
      end
   end

endmodule : okm_config

// ===== testbench/okm_config_properties.sv
// okm_config_properties: bus timing and field mapping checks.
// assumes master writes one byte at a time, next request two edges later.
`timescale 1ns/10ps
module okm_config_properties (
   // clock, reset, bus
   input wire logic I_SYS_CLK,
   input wire logic I_RST,
   input wire logic [8:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   input wire logic [31:0] O_AVS_READDATA,
   input wire logic O_AVS_WAITREQUEST,
   // fields
   input wire logic O_OOK_EN,
   input wire logic O_MANCH_TERM,
   input wire logic O_RATE_SCALE,
   input wire logic [15:0] O_DATA_RATE,
   input wire logic [16:0] O_EFF_RATE,
   input wire logic O_DIVIDE_BY_THREE_SKIP,
   input wire logic [2:0] O_DEC_EXP,
   input wire logic [3:0] O_FILSET,
   input wire logic [10:0] O_OSR,
   input wire logic [19:0] O_NCO_OFFSET,
   input wire logic [10:0] O_LOOP_GAIN
);
   logic wdone;
   logic [7:0] wd_r;
   default clocking @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RST);
   // keeps the last byte written so field checks see it after the write
   assign wdone = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_BYTEENABLE[0];
   always_ff @(posedge I_SYS_CLK) begin
      if (wdone) wd_r <= I_AVS_WRITEDATA[7:0];
   end
   property p_wait_one;
      (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("no answer");
   property p_wait_pulse; !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST; endproperty
   a_wait_pulse: assert property (p_wait_pulse)
      else $error("long ack");
   property p_rd_upper;
      I_AVS_READ && !O_AVS_WAITREQUEST |-> O_AVS_READDATA[31:8] == 24'h0;
   endproperty
   a_rd_upper: assert property (p_rd_upper)
      else $error("upper bits");
   property p_eff;
      ($stable(O_DATA_RATE) && $stable(O_MANCH_TERM))[*3] |->
         O_EFF_RATE == (O_MANCH_TERM ? {O_DATA_RATE, 1'b0}
            : {1'b0, O_DATA_RATE});
   endproperty
   a_eff: assert property (p_eff) else $error("eff rate");
   property p_ook;
      wdone && I_AVS_ADDRESS == 9'h1c4 |-> ##3
         O_OOK_EN == (wd_r[1:0] == 2'b01);
   endproperty
   a_ook: assert property (p_ook) else $error("mod type");
   property p_manch;
      wdone && I_AVS_ADDRESS == 9'h1c0 |-> ##3
         O_MANCH_TERM == wd_r[1] && O_RATE_SCALE == wd_r[5];
   endproperty
   a_manch: assert property (p_manch) else $error("manchester");
   property p_share;
      wdone && I_AVS_ADDRESS == 9'h084 |-> ##3
         O_OSR[10:8] == wd_r[7:5] && O_NCO_OFFSET[19:16] == wd_r[3:0];
   endproperty
   a_share: assert property (p_share) else $error("shared byte");
   property p_gain;
      wdone && I_AVS_ADDRESS == 9'h090 |-> ##3 O_LOOP_GAIN[10:8] == wd_r[2:0];
   endproperty
   a_gain: assert property (p_gain) else $error("loop gain");
   property p_filt;
      wdone && I_AVS_ADDRESS == 9'h070 |-> ##3
         O_DIVIDE_BY_THREE_SKIP == wd_r[7]
         && O_DEC_EXP == wd_r[6:4] && O_FILSET == wd_r[3:0];
   endproperty
   a_filt: assert property (p_filt) else $error("filter");
   property p_rate;
      wdone && I_AVS_ADDRESS == 9'h1b8 |-> ##3 O_DATA_RATE[15:8] == wd_r;
   endproperty
   a_rate: assert property (p_rate) else $error("rate high");
endmodule : okm_config_properties
bind okm_config okm_config_properties okm_config_properties_inst (
   .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
   .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
   .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE),
   .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
   .O_OOK_EN(O_OOK_EN), .O_MANCH_TERM(O_MANCH_TERM),
   .O_RATE_SCALE(O_RATE_SCALE), .O_DATA_RATE(O_DATA_RATE),
   .O_EFF_RATE(O_EFF_RATE), .O_DIVIDE_BY_THREE_SKIP(O_DIVIDE_BY_THREE_SKIP),
   .O_DEC_EXP(O_DEC_EXP), .O_FILSET(O_FILSET), .O_OSR(O_OSR),
   .O_NCO_OFFSET(O_NCO_OFFSET), .O_LOOP_GAIN(O_LOOP_GAIN));

// ===== testbench/okm_config_tb.sv
// okm_config_tb: register table loop, then byte enable, refusals, reset.
// assumes the property checker binds itself onto okm_config.
`timescale 1ns/10ps
module okm_config_tb;
   typedef struct {logic [8:0] a; logic [7:0] d; logic [7:0] q;} okm_row_t;
   logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
   logic [8:0] adr = 9'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [3:0] ben = 4'h1;
   logic wrq, on_off_keying, man, scl, skp, fv;
   logic [15:0] rate;
   logic [16:0] eff;
   logic [2:0] dex;
   logic [3:0] fset;
   logic [10:0] osr, gain;
   logic [19:0] nco;
   int errors = 0, num_checks = 0;
   okm_row_t rows [19] = '{
      '{9'h070, 8'h81, 8'h81}, '{9'h1fc, 8'h00, 8'h04},
      '{9'h070, 8'h87, 8'h87}, '{9'h1fc, 8'h00, 8'h00},
      '{9'h084, 8'hbf, 8'hbf}, '{9'h090, 8'hff, 8'hff},
      '{9'h040, 8'h55, 8'h00}, '{9'h1b8, 8'h12, 8'h12},
      '{9'h1bc, 8'h34, 8'h34}, '{9'h1c0, 8'h22, 8'h22},
      '{9'h1c4, 8'h01, 8'h01}, '{9'h080, 8'hd0, 8'hd0},
      '{9'h084, 8'h00, 8'h00}, '{9'h088, 8'h4e, 8'h4e},
      '{9'h08c, 8'ha5, 8'ha5}, '{9'h090, 8'h01, 8'h01},
      '{9'h094, 8'h3d, 8'h3d}, '{9'h070, 8'h31, 8'h31},
      '{9'h1fc, 8'hff, 8'h07}};
   logic [8:0] dadr [11] = '{9'h070, 9'h080, 9'h084, 9'h088, 9'h08c, 9'h090,
      9'h094, 9'h1b8, 9'h1bc, 9'h1c0, 9'h1c4};
   logic [7:0] dval [11] = '{okm_pkg::RST_IF_FILTER_BANDWIDTH,
      okm_pkg::RST_CR_OVERSAMPLE_RATIO, okm_pkg::RST_CR_OFFSET_2,
      okm_pkg::RST_CR_OFFSET_1, okm_pkg::RST_CR_OFFSET_0,
      okm_pkg::RST_CR_LOOP_GAIN_1, okm_pkg::RST_CR_LOOP_GAIN_0,
      okm_pkg::RST_TX_RATE_HIGH, okm_pkg::RST_TX_RATE_LOW,
      okm_pkg::RST_MODULATION_CONTROL_1, okm_pkg::RST_MODULATION_CONTROL_2};
   always #5 clk = ~clk;
   okm_config okm_config_inst (.I_SYS_CLK(clk), .I_RST(rst),
      .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
      .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(ben), .O_AVS_READDATA(rdat),
      .O_AVS_WAITREQUEST(wrq), .O_OOK_EN(on_off_keying), .O_MANCH_TERM(man),
      .O_RATE_SCALE(scl), .O_DATA_RATE(rate), .O_EFF_RATE(eff),
      .O_DIVIDE_BY_THREE_SKIP(skp), .O_DEC_EXP(dex), .O_FILSET(fset),
      .O_FILT_VALID(fv), .O_OSR(osr), .O_NCO_OFFSET(nco), .O_LOOP_GAIN(gain));
   task automatic finish_test;
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // entered just after an edge; a spare edge at the end keeps drivers clean
   task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d);
      int n;
      n = 0;
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (wrq !== 1'b0 && n < 20);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (wrq !== 1'b0) begin
         errors++;
         finish_test();
      end
      @(posedge clk);
   endtask : bus
   task automatic rchk(input logic [8:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h0);
      chk(q, {24'h0, e});
   endtask : rchk
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, rows[i].d);
         rchk(rows[i].a, rows[i].q);
      end
      chk(rate, 16'h1234);
      chk(eff, 17'h02468);
      chk(osr, 11'h0d0);
      chk(nco, 20'h04ea5);
      chk(gain, 11'h13d);
      chk({skp, dex, fset}, 8'h31);
      chk(scl, 1'b1);
      // byte lane 0 disabled: the write must leave the register alone
      ben <= 4'h0;
      bus(1'b1, 9'h1c0, 8'h00);
      ben <= 4'h1;
      rchk(9'h1c0, 8'h22);
      rchk(9'h1c1, 8'h00);
      bus(1'b1, 9'h1c0, 8'h00);
      repeat (3) @(posedge clk);
      chk(man, 1'b0);
      chk(eff, 17'h01234);
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, 9'h1c4, m[7:0]);
         repeat (3) @(posedge clk);
         chk(on_off_keying, m == 1);
      end
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (dadr[i]) rchk(dadr[i], dval[i]);
      chk(rate, {okm_pkg::RST_TX_RATE_HIGH,
         okm_pkg::RST_TX_RATE_LOW});
      finish_test();
   end
endmodule : okm_config_tb
